/* File: verilog/ledic_pkg.sv */
// Constants for the indicator control block: default word layout,
// selector codes and blink timing.
// Assumes a 100 MHz core clock.
package ledic_pkg;
  localparam int          LEDIC_WORD_W    = 16;
  localparam logic [15:0] LEDIC_WORD_RST  = 16'h18f4; // 0 0 0 110 0 0 111 1 0 100
  localparam int          LEDIC_RATE_BIT  = 15;
  localparam int          LEDIC_BLK2_BIT  = 14;
  localparam int          LEDIC_POL2_BIT  = 13;
  localparam int          LEDIC_SEL2_LSB  = 10;
  localparam int          LEDIC_BLK1_BIT  = 9;
  localparam int          LEDIC_POL1_BIT  = 8;
  localparam int          LEDIC_SEL1_LSB  = 5;
  localparam int          LEDIC_BLK0_BIT  = 4;
  localparam int          LEDIC_POL0_BIT  = 3;
  localparam int          LEDIC_SEL0_LSB  = 0;
  localparam int          LEDIC_SEL_W     = 3;
  localparam int          LEDIC_CLK_MHZ   = 100;
  localparam int          LEDIC_SLOW_MS   = 200;
  localparam int          LEDIC_FAST_MS   = 83;
  localparam int          LEDIC_SLOW_CYC  = LEDIC_SLOW_MS * 1000 * LEDIC_CLK_MHZ;
  localparam int          LEDIC_FAST_CYC  = LEDIC_FAST_MS * 1000 * LEDIC_CLK_MHZ;

  typedef enum logic [2:0] {
    LEDIC_M_L10_1000  = 3'h0,
    LEDIC_M_L100_1000 = 3'h1,
    LEDIC_M_LINK      = 3'h2,
    LEDIC_M_ACT       = 3'h3,
    LEDIC_M_LINK_IDLE = 3'h4,
    LEDIC_M_L10       = 3'h5,
    LEDIC_M_L100      = 3'h6,
    LEDIC_M_L1000     = 3'h7
  } ledic_mode_t;

  typedef enum logic [2:0] {
    LEDIC_SP_NONE = 3'h0,
    LEDIC_SP_10   = 3'h1,
    LEDIC_SP_100  = 3'h2,
    LEDIC_SP_1000 = 3'h4
  } ledic_speed_t;
endpackage

/* File: verilog/ledic_blink.sv */
// Shared blink phase generator for the indicator outputs.
// Assumes one core clock and a clock enable that freezes it.
`timescale 1ns/100ps
`default_nettype none
module ledic_blink
  import ledic_pkg::*;
#(
  parameter int SLOW_CYC = LEDIC_SLOW_CYC,
  parameter int FAST_CYC = LEDIC_FAST_CYC
)
(
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic fast_i,
  output logic      phase_o
);
  localparam int CW = $clog2(SLOW_CYC + 1);
  localparam logic [CW-1:0] SLOW_LAST = CW'(SLOW_CYC - 1);
  localparam logic [CW-1:0] FAST_LAST = CW'(FAST_CYC - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          ph_q;
  logic          ph_d;
  logic [CW-1:0] last;

  // Half period ends at the selected count; a rate change mid-phase
  // ends the phase early rather than wrapping the counter
  always_comb
  begin
    last  = fast_i ? FAST_LAST : SLOW_LAST;
    cnt_d = cnt_q;
    ph_d  = ph_q;
    if (ce_i)
    begin
      if (cnt_q >= last)
      begin
        cnt_d = '0;
        ph_d  = ~ph_q;
      end
      else
      begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  // Counter and phase registers
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q <= '0;
      ph_q  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      ph_q  <= ph_d;
    end
  end

  assign phase_o = ph_q;

  a_phase_len: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && cnt_q == '0 && $past(cnt_q) != '0) |-> (ph_q != $past(ph_q)))
    else $error("blink phase did not toggle at wrap");
endmodule
`default_nettype wire

/* File: verilog/ledic_cond.sv */
// Decodes a three-bit selector against link speed and activity.
// Assumes speed is one-hot or none and activity is a level.
`timescale 1ns/100ps
`default_nettype none
module ledic_cond
  import ledic_pkg::*;
(
  input  wire logic [2:0] sel_i,
  input  wire logic       sp10_i,
  input  wire logic       sp100_i,
  input  wire logic       sp1000_i,
  input  wire logic       act_i,
  output logic            cond_o
);
  logic link;

  // Selector decode of the condition
  always_comb
  begin
    link = sp10_i | sp100_i | sp1000_i;
    unique case (ledic_mode_t'(sel_i))
      LEDIC_M_L10_1000:  cond_o = sp10_i | sp1000_i;
      LEDIC_M_L100_1000: cond_o = sp100_i | sp1000_i;
      LEDIC_M_LINK:      cond_o = link;
      LEDIC_M_ACT:       cond_o = link & act_i;
      LEDIC_M_LINK_IDLE: cond_o = link & ~act_i;
      LEDIC_M_L10:       cond_o = sp10_i;
      LEDIC_M_L100:      cond_o = sp100_i;
      LEDIC_M_L1000:     cond_o = sp1000_i;
    endcase
  end
endmodule
`default_nettype wire

/* File: verilog/ledic_top.sv */
// Top of the indicator control block: holds the control word, decodes
// three conditions, applies blink and polarity, registers the pins.
// Assumes link speed and activity arrive synchronous to clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
module ledic_top
  import ledic_pkg::*;
#(
  parameter int SLOW_CYC = LEDIC_SLOW_CYC,
  parameter int FAST_CYC = LEDIC_FAST_CYC
)
(
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        load_i,
  input  wire logic [15:0] word_i,
  input  wire logic        sp10_i,
  input  wire logic        sp100_i,
  input  wire logic        sp1000_i,
  input  wire logic        act_i,
  output logic [15:0]      word_o,
  output logic [2:0]       led_o
);
  logic [15:0] word_q;
  logic [15:0] word_d;
  logic [2:0]  led_q;
  logic [2:0]  led_d;
  logic [2:0]  cond;
  logic [2:0]  on;
  logic        phase;

  // Field extraction for one output
  function automatic logic [2:0] sel_of(input logic [15:0] w, input int lsb);
    sel_of = w[lsb +: LEDIC_SEL_W];
  endfunction

  // Control word: reset default, replaced by the driver load;
  // power state plays no part, so the loaded word holds everywhere
  always_comb
  begin
    word_d = word_q;
    if (ce_i && load_i)
    begin
      word_d = word_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      word_q <= LEDIC_WORD_RST;
    end
    else
    begin
      word_q <= word_d;
    end
  end

  assign word_o = word_q;

  ledic_blink #(
    .SLOW_CYC (SLOW_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_blink (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .fast_i    (word_q[LEDIC_RATE_BIT]),
    .phase_o   (phase)
  );

  ledic_cond u_cond2 (
    .sel_i    (sel_of(word_q, LEDIC_SEL2_LSB)),
    .sp10_i   (sp10_i),
    .sp100_i  (sp100_i),
    .sp1000_i (sp1000_i),
    .act_i    (act_i),
    .cond_o   (cond[2])
  );

  ledic_cond u_cond1 (
    .sel_i    (sel_of(word_q, LEDIC_SEL1_LSB)),
    .sp10_i   (sp10_i),
    .sp100_i  (sp100_i),
    .sp1000_i (sp1000_i),
    .act_i    (act_i),
    .cond_o   (cond[1])
  );

  ledic_cond u_cond0 (
    .sel_i    (sel_of(word_q, LEDIC_SEL0_LSB)),
    .sp10_i   (sp10_i),
    .sp100_i  (sp100_i),
    .sp1000_i (sp1000_i),
    .act_i    (act_i),
    .cond_o   (cond[0])
  );

  // Logical on state, then pin level; polarity 0 means low is lit
  always_comb
  begin
    on[2] = cond[2] & (~word_q[LEDIC_BLK2_BIT] | phase);
    on[1] = cond[1] & (~word_q[LEDIC_BLK1_BIT] | phase);
    on[0] = cond[0] & (~word_q[LEDIC_BLK0_BIT] | phase);
    led_d = led_q;
    if (ce_i)
    begin
      led_d[2] = word_q[LEDIC_POL2_BIT] ? on[2] : ~on[2];
      led_d[1] = word_q[LEDIC_POL1_BIT] ? on[1] : ~on[1];
      led_d[0] = word_q[LEDIC_POL0_BIT] ? on[0] : ~on[0];
    end
  end

  // Pins come from flops so board loads see no decode glitches
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      led_q <= 3'h7; // Active-low default: all dark
    end
    else
    begin
      led_q <= led_d;
    end
  end

  assign led_o = led_q;

  // Word loading and freeze
  a_load_word: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && load_i) |=> (word_q == $past(word_i)))
    else $error("control word not loaded");
  a_hold_ce: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !ce_i |=> $stable(led_q) && $stable(word_q))
    else $error("state moved with enable low");

  // Steady outputs show the condition at the polarity level
  a_steady_on: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && cond[1] && !word_q[LEDIC_BLK1_BIT])
      |=> (led_q[1] == $past(word_q[LEDIC_POL1_BIT])))
    else $error("steady output one not lit");
  a_steady_two: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && cond[2] && !word_q[LEDIC_BLK2_BIT])
      |=> (led_q[2] == $past(word_q[LEDIC_POL2_BIT])))
    else $error("steady output two not lit");
  a_steady_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && cond[0] && !word_q[LEDIC_BLK0_BIT])
      |=> (led_q[0] == $past(word_q[LEDIC_POL0_BIT])))
    else $error("steady output zero not lit");

  // A false condition keeps the lamp dark whatever the blink state
  a_dark_false: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && !cond[2]) |=> (led_q[2] == !$past(word_q[LEDIC_POL2_BIT])))
    else $error("output two lit without condition");
  a_dark_one: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && !cond[1]) |=> (led_q[1] == !$past(word_q[LEDIC_POL1_BIT])))
    else $error("output one lit without condition");
  a_dark_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && !cond[0]) |=> (led_q[0] == !$past(word_q[LEDIC_POL0_BIT])))
    else $error("output zero lit without condition");

  // Blinking outputs follow the shared phase
  a_blink_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && cond[0] && word_q[LEDIC_BLK0_BIT] && !phase)
      |=> (led_q[0] == !$past(word_q[LEDIC_POL0_BIT])))
    else $error("blinking output zero lit in off phase");
  a_blink_on: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && cond[0] && word_q[LEDIC_BLK0_BIT] && phase)
      |=> (led_q[0] == $past(word_q[LEDIC_POL0_BIT])))
    else $error("blinking output zero dark in on phase");
  a_blink_off2: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && cond[2] && word_q[LEDIC_BLK2_BIT] && !phase)
      |=> (led_q[2] == !$past(word_q[LEDIC_POL2_BIT])))
    else $error("blinking output two lit in off phase");
  a_blink_off1: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && cond[1] && word_q[LEDIC_BLK1_BIT] && !phase)
      |=> (led_q[1] == !$past(word_q[LEDIC_POL1_BIT])))
    else $error("blinking output one lit in off phase");

  // Polarity decides the lit level
  a_pol_high: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && word_q[LEDIC_POL0_BIT] && on[0]) |=> led_q[0])
    else $error("active-high output zero not high");
  a_pol_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ce_i && !word_q[LEDIC_POL1_BIT] && on[1]) |=> !led_q[1])
    else $error("active-low output one not low");

  // Selector decode against the link inputs
  a_gig_sel: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (sel_of(word_q, LEDIC_SEL1_LSB) == LEDIC_M_L1000) |-> (cond[1] == sp1000_i))
    else $error("gigabit selector mismatch");
  a_idle_sel: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (sel_of(word_q, LEDIC_SEL0_LSB) == LEDIC_M_LINK_IDLE)
      |-> (cond[0] == ((sp10_i | sp100_i | sp1000_i) & !act_i)))
    else $error("link idle selector mismatch");
  a_fast_sel: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (sel_of(word_q, LEDIC_SEL2_LSB) == LEDIC_M_L100) |-> (cond[2] == sp100_i))
    else $error("100 Mb/s selector mismatch");
  a_act_sel: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (sel_of(word_q, LEDIC_SEL0_LSB) == LEDIC_M_ACT)
      |-> (cond[0] == ((sp10_i | sp100_i | sp1000_i) & act_i)))
    else $error("activity selector mismatch");

  // Main scenarios
  c_load: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) ce_i && load_i);
  c_blink: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    cond[0] && word_q[LEDIC_BLK0_BIT] ##1 $changed(led_q[0]));
  c_fast: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) word_q[LEDIC_RATE_BIT]);
  c_pol_high: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    word_q[LEDIC_POL0_BIT] && on[0]);
endmodule
`default_nettype wire

/* File: verification/ledic_board.sv */
// Board model of the three indicator lamps hung on led_o.
// Assumes the lamp polarity follows the polarity bits of the live word.
`timescale 1ns/100ps
`default_nettype none
module ledic_board
(
  input  wire logic [2:0] led_i,
  input  wire logic [2:0] pol_i,
  output logic [2:0]      lit_o
);
  // Lamp glows when the pin sits at its polarity level, so 0 means active-low
  assign lit_o = ~(led_i ^ pol_i);
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the indicator control block.
// Assumes short blink counts so a whole blink period fits in a few cycles.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ledic_pkg::*;
  localparam int SLOW = 8;
  localparam int FAST = 3;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        ce_i      = 1'b1;
  logic        load_i    = 1'b0;
  logic [15:0] word_i    = 16'h0000;
  logic [2:0]  sp_q      = 3'h0;
  logic        act_i     = 1'b0;
  logic [15:0] word_o;
  logic [2:0]  led_o;
  logic [2:0]  lit;
  logic [15:0] wblk;
  logic [2:0]  v;
  logic        c;
  int          n;
  int          miscompares = 0;
  int          checks_done = 0;

  ledic_top #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .ce_i(ce_i), .load_i(load_i), .word_i(word_i), .sp10_i(sp_q[0]), .sp100_i(sp_q[1]),
    .sp1000_i(sp_q[2]), .act_i(act_i), .word_o(word_o), .led_o(led_o));
  ledic_board board (.led_i(led_o), .pol_i({word_o[13], word_o[8], word_o[3]}), .lit_o(lit));

  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task close_out;
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Word is live one edge after the strobe
  task load(input logic [15:0] w);
    @(negedge clk_sys_i);
    load_i = 1'b1;
    word_i = w;
    @(negedge clk_sys_i);
    load_i = 1'b0;
    chk(word_o, w);
  endtask

  // Cycles until lamp zero changes; the two upper pins must stay put meanwhile
  task flip(input logic [1:0] up, output int cnt);
    logic l0;
    l0  = lit[0];
    cnt = 0;
    do
    begin
      @(negedge clk_sys_i);
      cnt++;
      chk({14'h0, led_o[2:1]}, {14'h0, up});
    end while (lit[0] === l0 && cnt < 40);
    if (cnt >= 40)
    begin
      miscompares++;
      close_out();
    end
  endtask

  // Reference decode of a selector against speed and activity
  function automatic logic cnd(input logic [2:0] s, input logic [2:0] sp, input logic a);
    logic up;
    up = |sp;
    case (s)
      3'h0: cnd = sp[0] | sp[2];
      3'h1: cnd = sp[1] | sp[2];
      3'h2: cnd = up;
      3'h3: cnd = up & a;
      3'h4: cnd = up & ~a;
      3'h5: cnd = sp[0];
      3'h6: cnd = sp[1];
      default: cnd = sp[2];
    endcase
  endfunction

  initial
  begin
    repeat (20) @(negedge clk_sys_i);
    chk(word_o, 16'h18f4);
    chk({13'h0, led_o}, 16'h0007);
    nrst_i = 1'b1;
    // Every selector against every speed and activity; out2 lit high, others lit low
    for (int s = 0; s < 8; s++)
    begin
      load({3'b001, 3'(s), 2'b00, 3'(s), 2'b00, 3'(s)});
      for (int k = 0; k < 8; k++)
      begin
        sp_q  = (k < 2) ? 3'h0 : 3'(1 << (k / 2 - 1));
        act_i = k[0];
        @(negedge clk_sys_i);
        c = cnd(3'(s), sp_q, act_i);
        chk({13'h0, led_o}, {13'h0, c, ~c, ~c});
      end
    end
    // Back-to-back loads keep the later word
    @(negedge clk_sys_i);
    load_i = 1'b1;
    word_i = 16'h5555;
    @(negedge clk_sys_i);
    word_i = 16'h2aaa;
    @(negedge clk_sys_i);
    load_i = 1'b0;
    chk(word_o, 16'h2aaa);
    // Out2 set to blink on a false condition stays dark, out1 steady lit high, out0 blinks on link
    sp_q  = 3'h2;
    act_i = 1'b0;
    wblk  = {3'b010, 3'h7, 2'b01, 3'h2, 2'b10, 3'h2};
    load(wblk);
    // Let the new word reach the pins so the first lamp change is a phase edge
    @(negedge clk_sys_i);
    for (int r = 0; r < 2; r++)
    begin
      if (r == 1)
      begin
        wblk[15] = 1'b1;
        load(wblk);
      end
      flip(2'b11, n);
      flip(2'b11, n);
      chk(16'(n), 16'(r ? FAST : SLOW));
      flip(2'b11, n);
      chk(16'(n), 16'(r ? FAST : SLOW));
    end
    // Clock enable low freezes the word and the pins, loads included
    @(negedge clk_sys_i);
    ce_i   = 1'b0;
    load_i = 1'b1;
    word_i = 16'h0000;
    v      = led_o;
    repeat (10) @(negedge clk_sys_i);
    chk(word_o, wblk);
    chk({13'h0, led_o}, {13'h0, v});
    load_i = 1'b0;
    ce_i   = 1'b1;
    // Reset in mid-run brings back the default word and its blinking out0
    nrst_i = 1'b0;
    @(negedge clk_sys_i);
    chk(word_o, 16'h18f4);
    nrst_i = 1'b1;
    flip(2'b01, n);
    flip(2'b01, n);
    chk(16'(n), 16'(SLOW));
    // All three blink on link, active-high, on one shared phase
    load(16'h6b5a);
    @(negedge clk_sys_i);
    v = led_o;
    n = 0;
    repeat (2 * SLOW)
    begin
      @(negedge clk_sys_i);
      chk({13'h0, led_o}, {13'h0, {3{lit[0]}}});
      if (led_o[1] !== v[1])
        n++;
      v = led_o;
    end
    chk(16'(n), 16'h0002);
    close_out();
  end
endmodule
`default_nettype wire
